// ===== include/pll_cfg_pkg.sv
/*
  constants for the clock multiplier configuration bank: register indices,
  field positions, reset values and bus codes.
  assumes byte address = 4 * register index on a 32-bit bus.
*/
package pll_cfg_pkg;
  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_DEV_CFG1 = 8'h03;
  localparam logic [7:0] IDX_GLOBAL_CFG = 8'h05;
  localparam logic [7:0] IDX_RATIO0 = 8'h06;
  localparam logic [7:0] IDX_RATIO3 = 8'h09;
  localparam logic [7:0] IDX_FUNC_CFG2 = 8'h17;
  localparam logic [7:0] IDX_LOOP_BW = 8'h1e;
  localparam logic [7:0] IDX_STATUS = 8'h20;
  // field positions
  localparam int EN1_BIT = 0;
  localparam int EN2_BIT = 0;
  localparam int FMT_BIT = 3;
  localparam int BW_LSB = 4;
  localparam int BW_MSB = 6;
  localparam int ST_RUN_BIT = 0;
  localparam int ST_LOCK_BIT = 1;
  // reset values
  localparam logic [2:0] BW_RST = 3'h0;
  localparam logic FMT_RST = 1'b0;
  localparam logic [7:0] RATIO_RST = 8'h00;
  // ratio split widths
  localparam int RATIO_W = 32;
  localparam int WIDE_W = 20;
  localparam int NARROW_W = 12;
  // ahb codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic HRESP_OKAY = 1'b0;
endpackage : pll_cfg_pkg

// ===== include/reg_access_if.sv
/*
  carrier between the bus slave and the register bank.
  assumes one clock domain, hclk.
*/
`timescale 1ns/1ps
interface reg_access_if;
  logic wr_stb;
  logic [7:0] wr_idx;
  logic [7:0] wr_data;
  logic [7:0] rd_idx;
  logic [7:0] rd_data;
  modport bus (output wr_stb, output wr_idx, output wr_data, output rd_idx,
               input rd_data);
  modport bank (input wr_stb, input wr_idx, input wr_data, input rd_idx,
                output rd_data);
endinterface : reg_access_if

// ===== verilog/ahb_byte_slave.sv
/*
  ahb-lite slave: zero-wait writes, reads with one wait state.
  assumes a single master and that hready is this slave's hreadyout.
*/
`timescale 1ns/1ps
module ahb_byte_slave (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic [31:0] hrdata,
  // register side
  reg_access_if.bus ra
);
  import pll_cfg_pkg::*;

  logic wr_pend_reg, wr_pend_next;
  logic rd_pend_reg, rd_pend_next;
  logic [7:0] idx_reg, idx_next;
  logic rdy_reg, rdy_next;
  logic [31:0] rdata_reg, rdata_next;
  logic take;

  // address phase accepted only on a ready bus
  assign take = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign ra.wr_stb = wr_pend_reg;
  assign ra.wr_idx = idx_reg;
  assign ra.wr_data = hwdata[7:0];
  assign ra.rd_idx = idx_reg;
  assign hreadyout = rdy_reg;
  assign hrdata = rdata_reg;

  // read data is sampled a cycle late so a write just before it is seen
  always_comb begin
    wr_pend_next = take && hwrite;
    rd_pend_next = take && !hwrite;
    idx_next = take ? haddr[9:2] : idx_reg;
    rdy_next = !(take && !hwrite);
    rdata_next = rd_pend_reg ? {24'h000000, ra.rd_data} : rdata_reg;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      idx_reg <= 8'h00;
      rdy_reg <= 1'b1;
      rdata_reg <= 32'h00000000;
    end else begin
      wr_pend_reg <= wr_pend_next;
      rd_pend_reg <= rd_pend_next;
      idx_reg <= idx_next;
      rdy_reg <= rdy_next;
      rdata_reg <= rdata_next;
    end
  end
endmodule : ahb_byte_slave

// ===== verilog/lock_bw_latch.sv
/*
  qualified lock state and the bandwidth code applied to the loop filter.
  assumes lock and reference-present levels synchronous to hclk.
*/
`timescale 1ns/1ps
module lock_bw_latch (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // qualifiers
  input wire logic pll_lock,
  input wire logic ref_present,
  input wire logic run,
  input wire logic [2:0] code_in,
  // results
  output logic locked,
  output logic [2:0] code_applied
);
  import pll_cfg_pkg::*;

  logic locked_reg, locked_next;
  logic [2:0] code_reg, code_next;

  assign locked = locked_reg;
  assign code_applied = code_reg;

  // a lost reference forces unlock, so the next lock re-latches
  always_comb begin
    locked_next = pll_lock && ref_present && run;
    code_next = code_reg;
    if (locked_next && !locked_reg) begin
      code_next = code_in; // taken only at lock acquisition
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      locked_reg <= 1'b0;
      code_reg <= BW_RST;
    end else begin
      locked_reg <= locked_next;
      code_reg <= code_next;
    end
  end
endmodule : lock_bw_latch

// ===== verilog/pll_ratio_format_and_loop_bw_cfg.sv
/*
  configuration bank for the clock multiplier: user ratio bytes, ratio
  format select, loop bandwidth code and the two device enables, reached
  over ahb-lite; drives the split ratio and the applied bandwidth.
  assumes the analog loop supplies a lock level and a reference-present
  level, both synchronous to hclk.
*/
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/1ps

// Function
// - one bit selects ratio integer/fraction split
// - select zero: 20 integer, 12 fraction
// - select one: 12 integer, 20 fraction
// - bandwidth code in bits six to four
// - code 000 is 1 Hz, doubling to 128
// - code written unlocked, applied at lock
// - reference loss forces unlock state
// - ratio bytes 06h-09h, MSB at lowest
// - operation needs both enables, any order
module pll_ratio_format_and_loop_bw_cfg (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // loop status in
  input wire logic pll_lock,
  input wire logic ref_present,
  // loop control out
  output logic run_enable,
  output logic loop_locked,
  output logic ratio_format_select,
  output logic [pll_cfg_pkg::WIDE_W-1:0] ratio_int,
  output logic [pll_cfg_pkg::WIDE_W-1:0] ratio_frac,
  output logic [2:0] input_loop_bandwidth_code,
  output logic [7:0] min_bw_hz
);
  import pll_cfg_pkg::*;

  reg_access_if ra ();

  // user ratio bytes, index 0 is the most significant
  logic [7:0] ratio_reg [4];
  logic [7:0] ratio_next [4];
  logic fmt_reg, fmt_next;
  logic [2:0] bw_reg, bw_next;
  logic en1_reg, en1_next;
  logic en2_reg, en2_next;

  // outputs to the loop
  logic run_reg, run_next;
  logic fmt_out_reg, fmt_out_next;
  logic [WIDE_W-1:0] int_reg, int_next;
  logic [WIDE_W-1:0] frac_reg, frac_next;
  logic [7:0] hz_reg, hz_next;

  // helpers
  logic [RATIO_W-1:0] user_defined_ratio;
  logic lock_q;
  logic [2:0] bw_applied;
  logic [7:0] rd_mux;
  logic [7:0] st_byte;
  logic resp_reg, resp_next;
  logic wr_en1;
  logic wr_en2;
  logic wr_fmt;
  logic wr_bw;
  logic wr_ratio;
  logic [1:0] ratio_sel;

  // bus front end
  ahb_byte_slave u_bus (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .hwdata(hwdata),
    .hreadyout(hreadyout),
    .hrdata(hrdata),
    .ra(ra.bus)
  );

  // lock qualification and bandwidth hand-over; the latch sees the stored
  // code, so a write in the very cycle of lock waits for the next lock
  lock_bw_latch u_lock (
    .hclk(hclk),
    .hresetn(hresetn),
    .pll_lock(pll_lock),
    .ref_present(ref_present),
    .run(run_reg),
    .code_in(bw_reg), // code comes from the unlocked-time write
    .locked(lock_q),
    .code_applied(bw_applied)
  );

  // assembled ratio, most significant byte at the lowest index; software
  // scales it for the chosen format, the bank stores it as written
  assign user_defined_ratio = {ratio_reg[0], ratio_reg[1],
                               ratio_reg[2], ratio_reg[3]};

  // status byte: own state for software to poll; it shows the applied code,
  // which may differ from the written one until the next lock
  always_comb begin
    st_byte = 8'h00;
    st_byte[ST_RUN_BIT] = run_reg;
    st_byte[ST_LOCK_BIT] = lock_q;
    st_byte[BW_MSB:BW_LSB] = bw_applied;
  end

  // write decode: one strobe per target, so each group of state below
  // only sees the writes meant for it
  always_comb begin
    wr_en1 = 1'b0;
    wr_en2 = 1'b0;
    wr_fmt = 1'b0;
    wr_bw = 1'b0;
    wr_ratio = 1'b0;
    if (ra.wr_stb) begin
      unique case (ra.wr_idx)
        IDX_DEV_CFG1: wr_en1 = 1'b1;
        IDX_GLOBAL_CFG: wr_en2 = 1'b1;
        IDX_FUNC_CFG2: wr_fmt = 1'b1;
        IDX_LOOP_BW: wr_bw = 1'b1;
        default: begin
          // ratio bytes sit at four consecutive indices
          wr_ratio = (ra.wr_idx >= IDX_RATIO0) && (ra.wr_idx <= IDX_RATIO3);
        end
      endcase
    end
  end

  // byte lane of the ratio, only meaningful while wr_ratio is high
  assign ratio_sel = 2'(ra.wr_idx - IDX_RATIO0);

  // user ratio bytes
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      ratio_next[i] = ratio_reg[i];
    end
    if (wr_ratio) begin
      ratio_next[ratio_sel] = ra.wr_data;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 4; i++) begin
        ratio_reg[i] <= RATIO_RST;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        ratio_reg[i] <= ratio_next[i];
      end
    end
  end

  // format select and bandwidth code; a code written while locked waits
  // here until the next lock picks it up
  always_comb begin
    fmt_next = wr_fmt ? ra.wr_data[FMT_BIT] : fmt_reg;
    bw_next = wr_bw ? ra.wr_data[BW_MSB:BW_LSB] : bw_reg;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fmt_reg <= FMT_RST;
      bw_reg <= BW_RST;
    end else begin
      fmt_reg <= fmt_next;
      bw_reg <= bw_next;
    end
  end

  // device enables, one bit in each of two registers; either may be set
  // first, run only follows once both are high
  always_comb begin
    en1_next = wr_en1 ? ra.wr_data[EN1_BIT] : en1_reg;
    en2_next = wr_en2 ? ra.wr_data[EN2_BIT] : en2_reg;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en1_reg <= 1'b0;
      en2_reg <= 1'b0;
    end else begin
      en1_reg <= en1_next;
      en2_reg <= en2_next;
    end
  end

  // read mux; reserved bits and unmapped indices read zero, so a read
  // of a hole never returns stale bus data
  always_comb begin
    rd_mux = 8'h00;
    unique case (ra.rd_idx)
      IDX_DEV_CFG1: rd_mux[EN1_BIT] = en1_reg;
      IDX_GLOBAL_CFG: rd_mux[EN2_BIT] = en2_reg;
      IDX_FUNC_CFG2: rd_mux[FMT_BIT] = fmt_reg;
      IDX_LOOP_BW: rd_mux[BW_MSB:BW_LSB] = bw_reg;
      IDX_STATUS: rd_mux = st_byte;
      default: begin
        if (ra.rd_idx >= IDX_RATIO0 && ra.rd_idx <= IDX_RATIO3) begin
          rd_mux = ratio_reg[2'(ra.rd_idx - IDX_RATIO0)];
        end
      end
    endcase
  end

  // read data goes back through the bus slave's own register
  assign ra.rd_data = rd_mux;

  // loop-side outputs; they hold their reset values until both enables
  // are set, which keeps a half-written ratio away from the synthesiser
  always_comb begin
    run_next = en1_reg && en2_reg; // order of setting is free
    fmt_out_next = fmt_out_reg;
    int_next = int_reg;
    frac_next = frac_reg;
    if (run_reg) begin // no ratio reaches the loop before run
      fmt_out_next = fmt_reg;
      if (!fmt_reg) begin
        // high multiplier: 20.12, fraction left-aligned
        int_next = user_defined_ratio[RATIO_W-1:NARROW_W];
        frac_next = {user_defined_ratio[NARROW_W-1:0],
                     {(WIDE_W-NARROW_W){1'b0}}};
      end else begin
        // high accuracy: 12.20, integer right-aligned
        int_next = {{(WIDE_W-NARROW_W){1'b0}},
                    user_defined_ratio[RATIO_W-1:WIDE_W]};
        frac_next = user_defined_ratio[WIDE_W-1:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_reg <= 1'b0;
      fmt_out_reg <= FMT_RST;
      int_reg <= '0;
      frac_reg <= '0;
    end else begin
      run_reg <= run_next;
      fmt_out_reg <= fmt_out_next;
      int_reg <= int_next;
      frac_reg <= frac_next;
    end
  end

  // minimum bandwidth in hertz doubles with each code step; it follows the
  // applied code one cycle late, never the code software last wrote
  always_comb begin
    hz_next = 8'h01 << bw_applied;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hz_reg <= 8'h01;
    end else begin
      hz_reg <= hz_next;
    end
  end

  // bus response: the answer never fails and only whole words are used, so
  // size is not looked at; it still leaves through a flop like the rest
  always_comb begin
    resp_next = HRESP_OKAY;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      resp_reg <= HRESP_OKAY;
    end else begin
      resp_reg <= resp_next;
    end
  end

  // top-level outputs straight from flops, so the loop and the bus never
  // see a combinational glitch from the register decode
  assign hresp = resp_reg;
  assign run_enable = run_reg;
  assign loop_locked = lock_q;
  assign ratio_format_select = fmt_out_reg;
  assign ratio_int = int_reg;
  assign ratio_frac = frac_reg;
  assign input_loop_bandwidth_code = bw_applied; // held until next lock
  assign min_bw_hz = hz_reg;

endmodule : pll_ratio_format_and_loop_bw_cfg

// ===== tb/pll_cfg_checker.sv
/*
  concurrent checks on the ports of the clock multiplier config bank.
  assumes one clock domain, hclk, and hready tied to hreadyout.
*/
`timescale 1ns/1ps
module pll_cfg_checker (
  // clock and reset
  input wire logic hclk, hresetn,
  // bus side
  input wire logic hsel, hwrite, hready, hreadyout, hresp,
  input wire logic [1:0] htrans,
  // loop side
  input wire logic pll_lock, ref_present, run_enable, loop_locked, ratio_format_select,
  input wire logic [19:0] ratio_int, ratio_frac,
  input wire logic [2:0] input_loop_bandwidth_code,
  input wire logic [7:0] min_bw_hz
);
  import pll_cfg_pkg::*;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // bus timing: reads take one wait state, writes none; response always okay
  chk_read_wait: assert property (hsel && hready && htrans == HTRANS_NONSEQ && !hwrite
    |=> !hreadyout ##1 hreadyout) else $error("read wait state wrong");
  chk_write_fast: assert property (hsel && hready && htrans == HTRANS_NONSEQ && hwrite
    |=> hreadyout) else $error("write stalled");
  chk_resp_okay: assert property (hresp == HRESP_OKAY) else $error("response not okay");
  // lock qualification, code hold while locked and bandwidth decode
  chk_run_gate: assert property (!run_enable |=> !loop_locked)
    else $error("locked while not running");
  chk_lock_rise: assert property (pll_lock && ref_present && run_enable |=> loop_locked)
    else $error("lock not taken");
  chk_ref_loss: assert property (!ref_present |=> !loop_locked)
    else $error("lock kept without reference");
  chk_code_hold: assert property ($past(loop_locked) && loop_locked
    |-> $stable(input_loop_bandwidth_code)) else $error("code moved while locked");
  chk_bw_decode: assert property (min_bw_hz == 8'h01 << $past(input_loop_bandwidth_code))
    else $error("bandwidth decode wrong");
  // fixed point split leaves the unused bits clear
  chk_fmt_wide: assert property (!ratio_format_select |-> ratio_frac[7:0] == 8'h00)
    else $error("20.12 fraction low bits set");
  chk_fmt_narrow: assert property (ratio_format_select |-> ratio_int[19:12] == 8'h00)
    else $error("12.20 integer high bits set");
endmodule : pll_cfg_checker

// ===== tb/tb.sv
/*
  self-checking bench for the config bank, driving ahb-lite and loop status.
  assumes the design's hand-over timing: one read wait state, 1-cycle lock.
*/
`timescale 1ns/1ps
module tb;
  import pll_cfg_pkg::*;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic pll_lock = 1'b0, ref_present = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'b00;
  logic hreadyout, hresp, run_enable, loop_locked, ratio_format_select;
  logic [19:0] ratio_int, ratio_frac;
  logic [2:0] input_loop_bandwidth_code;
  logic [7:0] min_bw_hz;
  int err_count = 0, n_tests = 0, cycles = 0;

  always #2.5 hclk = ~hclk;

  // hready loops back: this is the only slave on the bus
  pll_ratio_format_and_loop_bw_cfg u_pll_ratio_format_and_loop_bw_cfg (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .pll_lock(pll_lock), .ref_present(ref_present),
    .run_enable(run_enable), .loop_locked(loop_locked),
    .ratio_format_select(ratio_format_select), .ratio_int(ratio_int),
    .ratio_frac(ratio_frac), .input_loop_bandwidth_code(input_loop_bandwidth_code),
    .min_bw_hz(min_bw_hz));

  task automatic print_verdict();
    if (err_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask : tick

  // one single transfer; entered just after an edge, read data lands in rd
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    hwrite <= wr;
    htrans <= HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer

  task automatic wr_ratio(input logic [31:0] r);
    for (int k = 0; k < 4; k++) xfer(1'b1, IDX_RATIO0 + k[7:0], r[31-8*k -: 8]);
    xfer(1'b0, IDX_RATIO0, 8'h00);
    check("ratio_msb", rd, {24'h0, r[31:24]});
  endtask : wr_ratio

  // reset values, reserved bits and an unmapped place
  task automatic t_regs();
    xfer(1'b0, IDX_LOOP_BW, 8'h00);
    check("bw_rst", rd, 32'h0);
    check("min_bw_rst", min_bw_hz, 8'h01);
    xfer(1'b1, IDX_LOOP_BW, 8'hff);
    xfer(1'b0, IDX_LOOP_BW, 8'h00);
    check("bw_field", rd, 32'h70);
    xfer(1'b1, 8'h3f, 8'ha5);
    xfer(1'b0, 8'h3f, 8'h00);
    check("unmapped", rd, 32'h0);
  endtask : t_regs

  // code first, then enables in reverse order, then both formats
  task automatic t_bringup();
    xfer(1'b1, IDX_LOOP_BW, 8'h50);
    xfer(1'b1, IDX_GLOBAL_CFG, 8'h01);
    wr_ratio(32'h2df5e208);
    check("run_one_en", run_enable, 1'b0);
    xfer(1'b1, IDX_DEV_CFG1, 8'h01);
    tick(3);
    check("run", run_enable, 1'b1);
    check("int_2012", ratio_int, 20'h2df5e);
    check("frac_2012", ratio_frac, 20'h20800);
    xfer(1'b1, IDX_FUNC_CFG2, 8'h08);
    wr_ratio(32'h0013a92a);
    tick(3);
    check("fmt", ratio_format_select, 1'b1);
    check("int_1220", ratio_int, 20'h00001);
    check("frac_1220", ratio_frac, 20'h3a92a);
    pll_lock <= 1'b1;
    ref_present <= 1'b1;
    tick(3);
    check("first_lock", input_loop_bandwidth_code, 3'h5);
    ref_present <= 0;
    tick(2);
  endtask : t_bringup

  // every code: written unlocked, latched at lock, held, released on loss
  task automatic t_lock();
    logic [2:0] c;
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      xfer(1'b1, IDX_LOOP_BW, {1'b0, c, 4'h0});
      ref_present <= 1'b1;
      tick(3);
      check("bw_code", input_loop_bandwidth_code, c);
      check("min_bw_hz", min_bw_hz, 8'h01 << c);
      xfer(1'b0, IDX_STATUS, 8'h00);
      check("status", rd, {24'h0, 1'b0, c, 4'h3});
      xfer(1'b1, IDX_LOOP_BW, {1'b0, ~c, 4'h0});
      tick(2);
      check("bw_hold", input_loop_bandwidth_code, c);
      ref_present <= 1'b0;
      tick(2);
      check("unlocked", loop_locked, 1'b0);
    end
  endtask : t_lock

  // one enable cleared stops operation and lock
  task automatic t_run_gate();
    xfer(1'b1, IDX_DEV_CFG1, 8'h00);
    tick(2);
    ref_present <= 1'b1;
    tick(3);
    check("run_off", run_enable, 1'b0);
    check("no_lock", loop_locked, 1'b0);
  endtask : t_run_gate

  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_bringup();
    t_lock();
    t_run_gate();
    print_verdict();
  end

  // whole run needs well under a thousand cycles
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count++;
      print_verdict();
    end
  end
endmodule : tb

bind pll_ratio_format_and_loop_bw_cfg pll_cfg_checker u_pll_cfg_checker (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .htrans(htrans), .pll_lock(pll_lock),
  .ref_present(ref_present), .run_enable(run_enable), .loop_locked(loop_locked),
  .ratio_format_select(ratio_format_select), .ratio_int(ratio_int),
  .ratio_frac(ratio_frac), .input_loop_bandwidth_code(input_loop_bandwidth_code),
  .min_bw_hz(min_bw_hz));
